// File: hw/sigmon_readback_pkg.sv
// Package: register map, field layout, reset values and carriers of the readback framer
package sigmon_readback_pkg;

  // Bus geometry
  localparam int ADDR_W = 12;                      // AXI byte address width
  localparam int DATA_W = 32;                      // AXI data width
  localparam int IDX_W = 10;                       // Register index width (byte addr / 4)

  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_MON_CTRL = 10'h270;      // Peak detector enable
  localparam logic [IDX_W-1:0] IDX_PERIOD0 = 10'h271;       // Period bits 7:0
  localparam logic [IDX_W-1:0] IDX_PERIOD1 = 10'h272;       // Period bits 15:8
  localparam logic [IDX_W-1:0] IDX_PERIOD2 = 10'h273;       // Period bits 23:16
  localparam logic [IDX_W-1:0] IDX_STAT_CTRL = 10'h274;     // Update strobe, result select
  localparam logic [IDX_W-1:0] IDX_RESULT_LOW = 10'h275;    // monitor_result_low
  localparam logic [IDX_W-1:0] IDX_RESULT_MID = 10'h276;    // monitor_result_mid
  localparam logic [IDX_W-1:0] IDX_RESULT_HIGH = 10'h277;   // monitor_result_high
  localparam logic [IDX_W-1:0] IDX_FRAME_COUNT = 10'h278;   // monitor_frame_count
  localparam logic [IDX_W-1:0] IDX_FRAMER_EN = 10'h279;     // stats_framer_enable
  localparam logic [IDX_W-1:0] IDX_FRAMER_SEL = 10'h27A;    // stats_framer_input_select

  // Field positions
  localparam int PEAK_EN_BIT = 1;                  // Peak detector enable in control
  localparam int UPDATE_BIT = 4;                   // Self-clearing result update
  localparam int SEL_PEAK_BIT = 1;                 // Peak data in serial frame

  // Field codes and reset values
  localparam logic [2:0] RSEL_PEAK = 3'h1;         // Peak detector on readback
  localparam logic [2:0] RSEL_RST = 3'h1;          // Result selection after reset
  localparam logic [1:0] FEN_OFF = 2'h0;           // Framer insertion off
  localparam logic [1:0] FEN_ON = 2'h3;            // Framer insertion on
  localparam logic [23:0] PERIOD_RST = 24'h000080; // Monitoring period after reset
  localparam logic SEL_PEAK_RST = 1'b1;            // Peak insertion bit after reset

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;         // Normal access
  localparam logic [1:0] RESP_SLVERR = 2'h2;       // Unmapped address

  // Write and read channel states (Gray along the path)
  typedef enum logic [0:0] {W_IDLE = 1'b0, W_RESP = 1'b1} wr_e;
  typedef enum logic [0:0] {R_IDLE = 1'b0, R_DATA = 1'b1} rd_e;

  // AXI4-Lite master-to-slave signals
  typedef struct packed {
    logic awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic [2:0] awprot;
    logic wvalid;
    logic [DATA_W-1:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ADDR_W-1:0] araddr;
    logic [2:0] arprot;
    logic rready;
  } axil_req_s;

  // AXI4-Lite slave-to-master signals
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0] rresp;
  } axil_rsp_s;

  // Statistics word handed to the serial link framer
  typedef struct packed {
    logic valid;                                   // One-cycle pulse per period
    logic peakIncluded;                            // Peak field carries data
    logic [19:0] peak;                             // Peak statistic or zero
    logic [7:0] frameCount;                        // Running frame count
  } stats_frame_s;

endpackage

// File: hw/signal_monitor_readback_framer.sv
// Signal monitor readback registers, frame counter and statistics framer control
`timescale 1ns/1ps

module signal_monitor_readback_framer
  import sigmon_readback_pkg::*;
(
  input wire logic sys_clk,                              // 250 MHz output clock
  input wire logic rstn,                                 // Async reset, active low
  input wire sigmon_readback_pkg::axil_req_s axiReq,     // Register bus requests
  output sigmon_readback_pkg::axil_rsp_s axiRsp,         // Register bus answers
  input wire logic [19:0] peakLevel,                     // Peak detector output
  output logic peakDetEn,                                // Peak detector enable
  output sigmon_readback_pkg::stats_frame_s statsFrame   // Statistics to link framer
);

  // Whole state of the block
  typedef struct packed {
    wr_e wrSt;                 // Write channel state
    logic awHave;              // Write address held
    logic [ADDR_W-1:0] awAddr; // Held write address
    logic wHave;               // Write data held
    logic [DATA_W-1:0] wData;  // Held write data
    logic [3:0] wStrb;         // Held byte enables
    logic [1:0] bResp;         // Write response code
    rd_e rdSt;                 // Read channel state
    logic [DATA_W-1:0] rData;  // Read data register
    logic [1:0] rResp;         // Read response code
    logic peakEn;              // Peak detector enable
    logic [23:0] period;       // Monitoring period in cycles
    logic [2:0] resultSel;     // Readback source select
    logic updatePend;          // Update strobe, one cycle
    logic [19:0] result;       // Captured monitor result
    logic [7:0] frameCntReg;   // Captured frame count
    logic [7:0] frameCnt;      // Running frame count
    logic [23:0] perCnt;       // Period cycle counter
    logic [1:0] framerEn;      // Statistics insertion enable
    logic selPeak;             // Peak insertion select
    stats_frame_s stats;       // Framer output word
  } state_s;

  state_s state_r; // Registered state
  state_s state_nxt; // Next state
  logic expire; // Period counter wrap this cycle

  // Register index from a byte address
  function automatic logic [IDX_W-1:0] regIdx(input logic [ADDR_W-1:0] addr);
    regIdx = addr[ADDR_W-1:2];
  endfunction

  // Index falls inside the register map
  function automatic logic isMapped(input logic [IDX_W-1:0] idx);
    isMapped = (idx >= IDX_MON_CTRL) && (idx <= IDX_FRAMER_SEL);
  endfunction

  // Read mux; reserved bits and bits above the byte read as zero
  function automatic logic [DATA_W-1:0] readMux(input state_s s, input logic [IDX_W-1:0] idx);
    logic [7:0] b;
    b = 8'h00;
    if (idx == IDX_MON_CTRL) begin
      b[PEAK_EN_BIT] = s.peakEn;
    end else if (idx == IDX_PERIOD0) begin
      b = s.period[7:0];
    end else if (idx == IDX_PERIOD1) begin
      b = s.period[15:8];
    end else if (idx == IDX_PERIOD2) begin
      b = s.period[23:16];
    end else if (idx == IDX_STAT_CTRL) begin
      b[UPDATE_BIT] = s.updatePend;
      b[2:0] = s.resultSel;
    end else if (idx == IDX_RESULT_LOW) begin
      b = s.result[7:0];
    end else if (idx == IDX_RESULT_MID) begin
      b = s.result[15:8];
    end else if (idx == IDX_RESULT_HIGH) begin
      b = {4'h0, s.result[19:16]};
    end else if (idx == IDX_FRAME_COUNT) begin
      b = s.frameCntReg;
    end else if (idx == IDX_FRAMER_EN) begin
      b = {6'h00, s.framerEn};
    end else if (idx == IDX_FRAMER_SEL) begin
      b[SEL_PEAK_BIT] = s.selPeak;
    end
    readMux = {24'h000000, b};
  endfunction

  // Handshake outputs straight from state; data from flip-flops
  always_comb begin
    axiRsp.awready = !state_r.awHave && (state_r.wrSt == W_IDLE);
    axiRsp.wready = !state_r.wHave && (state_r.wrSt == W_IDLE);
    axiRsp.bvalid = (state_r.wrSt == W_RESP);
    axiRsp.bresp = state_r.bResp;
    axiRsp.arready = (state_r.rdSt == R_IDLE);
    axiRsp.rvalid = (state_r.rdSt == R_DATA);
    axiRsp.rdata = state_r.rData;
    axiRsp.rresp = state_r.rResp;
    peakDetEn = state_r.peakEn;
    statsFrame = state_r.stats;
  end

  // Period wrap; a zero period stops the monitor rather than wrapping every cycle
  assign expire = (state_r.period != 24'h000000) && (state_r.perCnt >= state_r.period - 24'h1);

  // Next-state logic for bus, registers, counters and framer
  always_comb begin
    logic [IDX_W-1:0] wIdx;
    logic [IDX_W-1:0] rIdx;
    wIdx = regIdx(state_r.awAddr);
    rIdx = regIdx(axiReq.araddr);
    state_nxt = state_r;
    state_nxt.updatePend = 1'b0;
    state_nxt.stats.valid = 1'b0;

    // Capture of results only on an update request; otherwise held
    if (state_r.updatePend) begin
      if (state_r.resultSel == RSEL_PEAK) begin
        state_nxt.result = peakLevel;
      end else begin
        state_nxt.result = 20'h00000; // Other sources live outside this block
      end
      state_nxt.frameCntReg = state_r.frameCnt;
    end

    // Period counter; odd periods are the caller's fault, counted as written
    if (expire) begin
      state_nxt.perCnt = 24'h000000;
      state_nxt.frameCnt = state_r.frameCnt + 8'h01;
      if (state_r.framerEn == FEN_ON) begin
        state_nxt.stats.valid = 1'b1;
        state_nxt.stats.peakIncluded = state_r.selPeak;
        state_nxt.stats.peak = state_r.selPeak ? peakLevel : 20'h00000;
        state_nxt.stats.frameCount = state_r.frameCnt + 8'h01;
      end
    end else if (state_r.period != 24'h000000) begin
      state_nxt.perCnt = state_r.perCnt + 24'h000001;
    end

    // Write address and data accepted in either order
    if (axiReq.awvalid && axiRsp.awready) begin
      state_nxt.awHave = 1'b1;
      state_nxt.awAddr = axiReq.awaddr;
    end
    if (axiReq.wvalid && axiRsp.wready) begin
      state_nxt.wHave = 1'b1;
      state_nxt.wData = axiReq.wdata;
      state_nxt.wStrb = axiReq.wstrb;
    end

    // Write channel
    case (state_r.wrSt)
      W_IDLE: begin
        if (state_r.awHave && state_r.wHave) begin
          state_nxt.awHave = 1'b0;
          state_nxt.wHave = 1'b0;
          state_nxt.wrSt = W_RESP;
          state_nxt.bResp = isMapped(wIdx) ? RESP_OKAY : RESP_SLVERR;
          // Only lane 0 carries register bits; read-only targets ignore writes
          if (state_r.wStrb[0]) begin
            if (wIdx == IDX_MON_CTRL) begin
              state_nxt.peakEn = state_r.wData[PEAK_EN_BIT];
            end else if (wIdx == IDX_PERIOD0) begin
              state_nxt.period[7:0] = state_r.wData[7:0];
            end else if (wIdx == IDX_PERIOD1) begin
              state_nxt.period[15:8] = state_r.wData[7:0];
            end else if (wIdx == IDX_PERIOD2) begin
              state_nxt.period[23:16] = state_r.wData[7:0];
            end else if (wIdx == IDX_STAT_CTRL) begin
              state_nxt.resultSel = state_r.wData[2:0];
              state_nxt.updatePend = state_r.wData[UPDATE_BIT];
            end else if (wIdx == IDX_FRAMER_EN) begin
              state_nxt.framerEn = state_r.wData[1:0];
            end else if (wIdx == IDX_FRAMER_SEL) begin
              state_nxt.selPeak = state_r.wData[SEL_PEAK_BIT];
            end
          end
        end
      end
      W_RESP: begin
        if (axiReq.bready) begin
          state_nxt.wrSt = W_IDLE;
        end
      end
      default: begin
        state_nxt.wrSt = W_IDLE;
      end
    endcase

    // Read channel; data registered so rdata is stable while rvalid stands
    case (state_r.rdSt)
      R_IDLE: begin
        if (axiReq.arvalid) begin
          state_nxt.rdSt = R_DATA;
          state_nxt.rData = readMux(state_r, rIdx);
          state_nxt.rResp = isMapped(rIdx) ? RESP_OKAY : RESP_SLVERR;
        end
      end
      R_DATA: begin
        if (axiReq.rready) begin
          state_nxt.rdSt = R_IDLE;
        end
      end
      default: begin
        state_nxt.rdSt = R_IDLE;
      end
    endcase
  end

  // State register with documented reset values
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= '0;
      state_r.wrSt <= W_IDLE;
      state_r.rdSt <= R_IDLE;
      state_r.period <= PERIOD_RST;
      state_r.resultSel <= RSEL_RST;
      state_r.framerEn <= FEN_OFF;
      state_r.selPeak <= SEL_PEAK_RST;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Checks on the block's outputs and internal state
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);

  // Update request followed by capture of the selected source
  sequence s_peak_update;
    state_r.updatePend && (state_r.resultSel == RSEL_PEAK);
  endsequence

  property p_peak_readback;
    s_peak_update |=> (state_r.result == $past(peakLevel));
  endproperty
  a_peak_readback: assert property (p_peak_readback)
    else $error("peak level not captured on update");

  property p_result_low_read;
    (axiReq.arvalid && axiRsp.arready && (regIdx(axiReq.araddr) == IDX_RESULT_LOW))
      |=> axiRsp.rvalid && (axiRsp.rdata == {24'h000000, $past(state_r.result[7:0])});
  endproperty
  a_result_low_read: assert property (p_result_low_read)
    else $error("result low byte read wrong");

  property p_result_high_read;
    (axiReq.arvalid && axiRsp.arready && (regIdx(axiReq.araddr) == IDX_RESULT_HIGH))
      |=> (axiRsp.rdata[31:4] == 28'h0000000)
        && (axiRsp.rdata[3:0] == $past(state_r.result[19:16]));
  endproperty
  a_result_high_read: assert property (p_result_high_read)
    else $error("result high nibble read wrong");

  property p_frame_increment;
    expire |=> (state_r.frameCnt == $past(state_r.frameCnt) + 8'h01);
  endproperty
  a_frame_increment: assert property (p_frame_increment)
    else $error("frame counter missed a period expiry");

  property p_framer_gate;
    statsFrame.valid |-> ($past(state_r.framerEn) == FEN_ON) && $past(expire);
  endproperty
  a_framer_gate: assert property (p_framer_gate)
    else $error("statistics sent while framer disabled");

  property p_peak_inserted;
    (expire && (state_r.framerEn == FEN_ON) && state_r.selPeak)
      |=> statsFrame.valid && statsFrame.peakIncluded && (statsFrame.peak == $past(peakLevel));
  endproperty
  a_peak_inserted: assert property (p_peak_inserted)
    else $error("peak data missing from frame");

  property p_peak_omitted;
    statsFrame.valid && !statsFrame.peakIncluded |-> (statsFrame.peak == 20'h00000);
  endproperty
  a_peak_omitted: assert property (p_peak_omitted)
    else $error("peak data present though deselected");

  sequence s_update_pulse;
    state_r.updatePend ##1 !state_r.updatePend;
  endsequence

  property p_update_clears;
    state_r.updatePend && !$past(state_r.updatePend) |-> s_update_pulse;
  endproperty
  a_update_clears: assert property (p_update_clears)
    else $error("update bit did not clear itself");

  property p_results_hold;
    !state_r.updatePend |=> $stable(state_r.result) && $stable(state_r.frameCntReg);
  endproperty
  a_results_hold: assert property (p_results_hold)
    else $error("results changed without update");

  // Middle byte; compared with the result as it stood when the address was taken
  property p_result_mid_read;
    (axiReq.arvalid && axiRsp.arready && (regIdx(axiReq.araddr) == IDX_RESULT_MID))
      |=> axiRsp.rvalid && (axiRsp.rdata == {24'h000000, $past(state_r.result[15:8])});
  endproperty
  a_result_mid_read: assert property (p_result_mid_read)
    else $error("result middle byte read wrong");

  // Frame count snapshot follows the running count on an update
  property p_count_capture;
    state_r.updatePend |=> (state_r.frameCntReg == $past(state_r.frameCnt));
  endproperty
  a_count_capture: assert property (p_count_capture)
    else $error("frame count not captured on update");

  // Sources other than the peak detector read back as zero here
  property p_other_source_zero;
    state_r.updatePend && (state_r.resultSel != RSEL_PEAK) |=> (state_r.result == 20'h00000);
  endproperty
  a_other_source_zero: assert property (p_other_source_zero)
    else $error("unselected source reached readback");

  // Codes 00, 01 and 10 all keep the link quiet
  property p_framer_off;
    (state_r.framerEn != FEN_ON) |=> !statsFrame.valid;
  endproperty
  a_framer_off: assert property (p_framer_off)
    else $error("frame sent with insertion off");

  // Frame carries the count that the expiry produced
  property p_count_in_frame;
    expire && (state_r.framerEn == FEN_ON) |=> (statsFrame.frameCount == state_r.frameCnt);
  endproperty
  a_count_in_frame: assert property (p_count_in_frame)
    else $error("frame count in frame wrong");

  // Counter moves only on an expiry
  property p_count_still;
    !expire |=> $stable(state_r.frameCnt);
  endproperty
  a_count_still: assert property (p_count_still)
    else $error("frame counter moved without expiry");

  // Only byte lane 0 carries register bits
  property p_upper_zero;
    axiRsp.rvalid |-> (axiRsp.rdata[31:8] == 24'h000000);
  endproperty
  a_upper_zero: assert property (p_upper_zero)
    else $error("upper read data bits not zero");

endmodule

// File: tb/signal_monitor_readback_framer_tb.sv
// Testbench of the monitor readback registers and statistics framer
`timescale 1ns/1ps

module signal_monitor_readback_framer_tb;
  import sigmon_readback_pkg::*;

  localparam int LIMIT = 3000; // Cycle ceiling, tests need far fewer
  localparam logic [87:0] RST_TAB = 88'h0200000000000100008000; // Reset bytes 0x270 up

  logic sysClk; // 4 ns clock
  logic rstn; // Reset, active low
  axil_req_s axiReq; // Bus requests
  axil_rsp_s axiRsp; // Bus answers
  logic [19:0] peakLevel; // Peak detector stand-in
  logic peakDetEn; // Peak enable from block
  stats_frame_s statsFrame; // Frames to the link
  stats_frame_s lastFrame; // Latest frame seen by the sink
  logic [15:0] pulseCount, lastGap, countSteps, p0, s0; // Sink counters and snapshots
  logic [31:0] rdData; // Last read data
  logic [1:0] rdResp; // Last read response
  logic [7:0] fc; // Frozen frame count
  int badCount, totalChecks; // Mismatches and comparisons
  int cycles = 0; // Watchdog count

  signal_monitor_readback_framer dut_u (
    .sys_clk(sysClk), .rstn(rstn), .axiReq(axiReq), .axiRsp(axiRsp),
    .peakLevel(peakLevel), .peakDetEn(peakDetEn), .statsFrame(statsFrame));

  stats_frame_sink sink_u (
    .sys_clk(sysClk), .rstn(rstn), .statsFrame(statsFrame), .pulseCount(pulseCount),
    .lastFrame(lastFrame), .lastGap(lastGap), .countSteps(countSteps));

  // Clock
  always #2 sysClk = ~sysClk;

  // Watchdog against a bus that never answers
  always @(posedge sysClk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      badCount++;
      conclude();
    end
  end

  // Verdict and end of run
  task automatic conclude();
    $display("Checks made %0d, mismatches %0d", totalChecks, badCount);
    if (badCount == 0 && totalChecks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Data compare
  task automatic chkVal(input logic [31:0] got, input logic [31:0] exp, input string what);
    totalChecks++;
    if (got !== exp) begin
      badCount++;
      $display("BAD t=%0t %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // Response code compare
  task automatic chkResp(input logic [1:0] got, input logic [1:0] exp, input string what);
    chkVal({30'h0, got}, {30'h0, exp}, what);
  endtask

  // Write: both channels offered together, each dropped at its own handshake
  task automatic busWrite(input logic [IDX_W-1:0] idx, input logic [7:0] val,
                          output logic [1:0] resp);
    logic aHit, wHit, bHit;
    bHit = 1'b0;
    @(posedge sysClk);
    axiReq.awaddr <= {idx, 2'b00};
    axiReq.wdata <= {24'h0, val};
    axiReq.wstrb <= 4'hF;
    axiReq.awvalid <= 1'b1;
    axiReq.wvalid <= 1'b1;
    axiReq.bready <= 1'b1;
    while (!bHit) begin
      // Looking mid-cycle shows what the next edge will take
      @(negedge sysClk);
      aHit = axiReq.awvalid & axiRsp.awready;
      wHit = axiReq.wvalid & axiRsp.wready;
      bHit = axiRsp.bvalid;
      resp = axiRsp.bresp;
      @(posedge sysClk);
      if (aHit) axiReq.awvalid <= 1'b0;
      if (wHit) axiReq.wvalid <= 1'b0;
    end
    axiReq.bready <= 1'b0;
  endtask

  // Read: address held until taken, data taken with rvalid
  task automatic busRead(input logic [IDX_W-1:0] idx, output logic [31:0] data,
                         output logic [1:0] resp);
    logic arHit, rHit;
    rHit = 1'b0;
    @(posedge sysClk);
    axiReq.araddr <= {idx, 2'b00};
    axiReq.arvalid <= 1'b1;
    axiReq.rready <= 1'b1;
    while (!rHit) begin
      @(negedge sysClk);
      arHit = axiReq.arvalid & axiRsp.arready;
      rHit = axiRsp.rvalid;
      data = axiRsp.rdata;
      resp = axiRsp.rresp;
      @(posedge sysClk);
      if (arHit) axiReq.arvalid <= 1'b0;
    end
    axiReq.rready <= 1'b0;
  endtask

  // Write with expected response
  task automatic wr(input logic [IDX_W-1:0] idx, input logic [7:0] val, input logic [1:0] er);
    logic [1:0] resp;
    busWrite(idx, val, resp);
    chkResp(resp, er, "write response");
  endtask

  // Read of a mapped byte register, upper bits zero
  task automatic rd(input logic [IDX_W-1:0] idx, input logic [7:0] exp);
    busRead(idx, rdData, rdResp);
    chkResp(rdResp, RESP_OKAY, "read response");
    chkVal(rdData, {24'h0, exp}, "read data");
  endtask

  // Main sequence
  initial begin
    sysClk = 1'b0;
    rstn = 1'b0;
    axiReq = '0;
    peakLevel = 20'hABCDE;
    badCount = 0;
    totalChecks = 0;
    repeat (5) @(posedge sysClk);
    rstn <= 1'b1;
    // Result writes are accepted but change nothing
    for (int i = 5; i < 9; i++) wr(IDX_MON_CTRL + 10'(i), 8'hFF, RESP_OKAY);
    for (int i = 0; i < 11; i++) rd(IDX_MON_CTRL + 10'(i), RST_TAB[8*i +: 8]);
    wr(IDX_MON_CTRL, 8'hFF, RESP_OKAY);
    chkVal({31'h0, peakDetEn}, 32'h1, "peak enable pin");
    rd(IDX_MON_CTRL, 8'h02);
    // Unmapped places answer with an error and no data
    wr(10'h27B, 8'h01, RESP_SLVERR);
    busRead(10'h26F, rdData, rdResp);
    chkResp(rdResp, RESP_SLVERR, "unmapped read");
    chkVal(rdData, 32'h0, "unmapped data");
    // Short even period with insertion on: a frame every four cycles
    wr(IDX_PERIOD0, 8'h04, RESP_OKAY);
    wr(IDX_FRAMER_EN, {6'h0, FEN_ON}, RESP_OKAY);
    repeat (12) @(posedge sysClk);
    p0 = pulseCount;
    s0 = countSteps;
    repeat (40) @(posedge sysClk);
    chkVal({16'h0, pulseCount - p0}, 32'hA, "frames per window");
    chkVal({16'h0, countSteps - s0}, 32'hA, "frame count steps");
    chkVal({16'h0, lastGap}, 32'h4, "frame spacing");
    chkVal({12'h0, lastFrame.peak}, 32'hABCDE, "peak in frame");
    chkVal({31'h0, lastFrame.peakIncluded}, 32'h1, "peak flag");
    // Period zero stops counting so the count can be compared
    wr(IDX_PERIOD0, 8'h00, RESP_OKAY);
    repeat (8) @(posedge sysClk);
    fc = lastFrame.frameCount;
    wr(IDX_STAT_CTRL, 8'h11, RESP_OKAY);
    rd(IDX_STAT_CTRL, 8'h01);
    rd(IDX_RESULT_LOW, 8'hDE);
    rd(IDX_RESULT_MID, 8'hBC);
    rd(IDX_RESULT_HIGH, 8'h0A);
    rd(IDX_FRAME_COUNT, fc);
    // A new peak must not show before the next update
    peakLevel <= 20'h12345;
    rd(IDX_RESULT_LOW, 8'hDE);
    wr(IDX_STAT_CTRL, 8'h12, RESP_OKAY);
    rd(IDX_RESULT_LOW, 8'h00);
    rd(IDX_RESULT_HIGH, 8'h00);
    wr(IDX_STAT_CTRL, 8'h11, RESP_OKAY);
    rd(IDX_RESULT_LOW, 8'h45);
    rd(IDX_RESULT_MID, 8'h23);
    rd(IDX_RESULT_HIGH, 8'h01);
    // Counter running again; every code but 11 sends nothing
    wr(IDX_PERIOD0, 8'h04, RESP_OKAY);
    for (int c = 0; c < 3; c++) begin
      wr(IDX_FRAMER_EN, 8'(c), RESP_OKAY);
      repeat (4) @(posedge sysClk);
      p0 = pulseCount;
      repeat (20) @(posedge sysClk);
      chkVal({16'h0, pulseCount - p0}, 32'h0, "frames while off");
    end
    // Peak left out of the frame when its selection bit is clear
    wr(IDX_FRAMER_SEL, 8'h00, RESP_OKAY);
    rd(IDX_FRAMER_SEL, 8'h00);
    wr(IDX_FRAMER_EN, {6'h0, FEN_ON}, RESP_OKAY);
    repeat (12) @(posedge sysClk);
    chkVal({31'h0, lastFrame.peakIncluded}, 32'h0, "peak flag off");
    chkVal({12'h0, lastFrame.peak}, 32'h0, "peak omitted");
    wr(IDX_FRAMER_SEL, 8'hFF, RESP_OKAY);
    rd(IDX_FRAMER_SEL, 8'h02);
    conclude();
  end
endmodule

// File: tb/stats_frame_sink.sv
// Link-side receiver model that collects statistics frames from the block
`timescale 1ns/1ps

module stats_frame_sink
  import sigmon_readback_pkg::*;
(
  input wire logic sys_clk,                                  // Output clock
  input wire logic rstn,                                     // Async reset, active low
  input wire sigmon_readback_pkg::stats_frame_s statsFrame,  // Frames from the block
  output logic [15:0] pulseCount,                            // Frames received
  output sigmon_readback_pkg::stats_frame_s lastFrame,       // Latest frame payload
  output logic [15:0] lastGap,                               // Cycles between last two frames
  output logic [15:0] countSteps                             // Frames whose count rose by one
);
  logic [15:0] gapCnt; // Cycles since the previous frame

  // Receiver never stalls; it only takes frames as they come
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pulseCount <= 16'h0;
      lastFrame <= '0;
      lastGap <= 16'h0;
      countSteps <= 16'h0;
      gapCnt <= 16'h0;
    end else begin
      gapCnt <= gapCnt + 16'h1;
      if (statsFrame.valid) begin
        // Spacing includes the frame cycle itself
        pulseCount <= pulseCount + 16'h1;
        lastFrame <= statsFrame;
        lastGap <= gapCnt + 16'h1;
        gapCnt <= 16'h0;
        // Skipped or repeated counts show up as missing steps
        if (statsFrame.frameCount == lastFrame.frameCount + 8'h1) begin
          countSteps <= countSteps + 16'h1;
        end
      end
    end
  end
endmodule
